// File: rtl/port_cfg_pkg.sv
// Package with register map, field positions and reset values of the port configuration block.
package port_cfg_pkg;
    // APB byte addresses; the printed offsets are all multiples of four.
    localparam logic [11:0] ADDR_PORT_ZERO_DATA      = 12'h000;
    localparam logic [11:0] ADDR_PORT_ZERO_DIRECTION = 12'h0f8;
    localparam logic [11:0] ADDR_PORT_OUTPUT_CONFIG  = 12'hf00;
    localparam logic [11:0] ADDR_FOURTH_PORT_INPUT   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STATUS          = 12'hf04;
    localparam logic [11:0] ADDR_IRQ_MASK            = 12'hf08;
    // Field positions.
    localparam int CFG_COMP_OUT_BIT   = 0;
    localparam int CFG_PUSH_PULL_BIT  = 2;
    localparam int DIR_LOW_NIBBLE_BIT = 0;
    localparam int DIR_HIGH_NIBBLE_BIT = 6;
    localparam int SERIAL_TX_EN_BIT   = 7;
    localparam int MODE_ANALOG_BIT    = 1;
    localparam int MODE_IR_AMP_BIT    = 2;
    localparam int TX_PIN_BIT         = 7;
    localparam int P3_IN_BIT3         = 3;
    localparam int P3_REF_ONE_BIT     = 0;
    localparam int P3_CMP_ONE_BIT     = 1;
    localparam int P3_CMP_TWO_BIT     = 2;
    localparam int TMR_ONE_SEL_HI_BIT = 5;
    localparam int TMR_ONE_SEL_LO_BIT = 4;
    localparam int TMR_ZERO_SEL_BIT   = 0;
    localparam int TMR_TWO_SEL_BIT    = 0;
    // Port geometry.
    localparam int PORT_WIDTH         = 8;
    localparam int NIBBLE_WIDTH       = 4;
    localparam int P3_WIDTH           = 4;
    // Reset value of the output latch.
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Fixed read patterns of reserved bits.
    localparam logic [7:0] CFG_READ_VALUE = 8'hff;
    localparam logic [7:0] DIR_RESERVED_ONES = 8'hbe;
    // Interrupt status bits.
    localparam int IRQ_EXT_B_BIT = 0;
    localparam int IRQ_RECOVERY_BIT = 1;
    localparam int IRQ_WIDTH = 2;
endpackage

// File: rtl/p3_output_mux.sv
// Output routing for the four fixed outputs of the fourth port.
`timescale 1ns/1ns
module p3_output_mux
(
    // Selection controls
    input  wire logic       comp_out_en,
    input  wire logic       ir_amp_sel,
    input  wire logic       timer_one_b5,
    input  wire logic       timer_one_b4,
    input  wire logic       timer_zero_b0,
    input  wire logic       timer_two_b0,
    // Sources
    input  wire logic [3:0] digital_out,
    input  wire logic       eight_bit_timer_output,
    input  wire logic       sixteen_bit_timer_output,
    input  wire logic       combine_logic_out,
    input  wire logic       comparator_one_output,
    input  wire logic       comparator_two_output,
    input  wire logic       infrared_amplifier_output,
    // Result for pins 4 to 7
    output logic      [3:0] pin_out
);
    // Timer sources come first, then comparators override when enabled.
    always_comb
    begin
        pin_out = digital_out;
        if (timer_zero_b0)
            pin_out[0] = eight_bit_timer_output;
        if (timer_two_b0)
            pin_out[1] = sixteen_bit_timer_output;
        unique case ({timer_one_b5, timer_one_b4})
            2'b01:   pin_out[2] = eight_bit_timer_output;
            2'b10:   pin_out[2] = sixteen_bit_timer_output;
            2'b11:   pin_out[2] = combine_logic_out;
            default: pin_out[2] = digital_out[2];
        endcase
        if (comp_out_en)
        begin
            pin_out[0] = ir_amp_sel ? infrared_amplifier_output : comparator_one_output;
            pin_out[3] = comparator_two_output;
        end
    end
endmodule // p3_output_mux

// File: rtl/port_config_and_nibble_io.sv
// Port configuration, first-port nibble I/O and fourth-port routing with an APB slave.
//
// Behaviour
// - Timer and combining logic outputs reach fourth-port output pins per timer controls.
// - Analog mode gives fourth-port inputs one and two comparator front ends.
// - Analog mode diverts fourth input latch and interrupt to recovery sources.
// - Digital mode shows fourth input as input bit 3 and raises interrupt b.
// - Config bit 0 routes comparators onto output pins four and seven.
// - Config bit 2 selects open-drain or push/pull, write-only, reads one.
// - Reserved config bits ignore writes; read as ones.
// - Config register survives stop-mode recovery; only hardware reset clears it.
// - Direction bit 6 sets upper nibble: zero output, one input.
// - Direction bit 0 sets lower nibble: zero output, one input.
// - Data register reads return actual pin levels.
// - Writing zero drives low; one drives high or floats under open-drain.
// - Pin 7 is general I/O only while serial transmit is disabled.
// - Fourth-port mode bit 1 selects analog mode.
// - Enabled serial transmitter replaces pin 7 output with transmit data.
//
// Register map, each register in the low byte of its own word:
//   port_zero_data             writes load the latch, reads return the pins.
//   port_zero_direction        one bit per nibble, a one makes it an input.
//   port_output_configuration  drive mode and comparator routing; reads ones.
//   fourth port input view     pins, or analog results in analog mode.
//   interrupt status           sticky, write one to clear; an event wins.
//   interrupt mask             irq is the OR of the enabled status bits.
//
// Hazards and limitations:
//   Data reads return the pins, not the latch. An open-drain one held low
//   outside reads back as zero, and a read-modify-write then stores it.
//   Software that needs the latched value keeps its own copy.
//   There is no stop-mode recovery input; only presetn clears settings.
//   The bus never waits: pready is tied high, every access is two cycles.
//   Configuration bits are write-only; software keeps its own copy.
//   The two interrupt outputs are one-cycle pulses; irq is the level.
//   Fourth-port inputs are taken as synchronous to pclk; an asynchronous
//   source needs a synchroniser in front or the edge detector sees runts.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
module port_config_and_nibble_io
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // First port pins
    input  wire logic [7:0]  port_zero_in,
    output logic      [7:0]  port_zero_out,
    output logic      [7:0]  port_zero_oe,
    // Controls owned by other blocks
    input  wire logic [7:0]  serial_control,
    input  wire logic        serial_tx_data,
    input  wire logic [7:0]  fourth_port_mode,
    input  wire logic [7:0]  timer_control_zero,
    input  wire logic [7:0]  timer_control_one,
    input  wire logic [7:0]  timer_control_two,
    // Fourth port inputs and analog results
    input  wire logic [3:0]  fourth_port_in,
    input  wire logic        comparator_one_result,
    input  wire logic        comparator_two_result,
    input  wire logic        infrared_amplifier_output,
    input  wire logic        recovery_condition_n,
    // Fourth port output sources
    input  wire logic [3:0]  fourth_port_digital_out,
    input  wire logic        eight_bit_timer_output,
    input  wire logic        sixteen_bit_timer_output,
    input  wire logic        combine_logic_out,
    // Fourth port outputs and analog control
    output logic      [3:0]  fourth_port_out,
    output logic             comparator_enable,
    output logic             external_interrupt_b,
    output logic             recovery_interrupt,
    output logic             irq
);
    // Address decode of the current access. All twelve bits are compared,
    // so no register has aliases; anything else is an error.
    logic access;
    logic wr_en;
    logic hit_data;
    logic hit_dir;
    logic hit_cfg;
    logic hit_p3;
    logic hit_sts;
    logic hit_msk;
    logic hit_any;
    assign access   = psel && penable;
    assign wr_en    = access && pwrite;
    assign hit_data = (paddr == port_cfg_pkg::ADDR_PORT_ZERO_DATA);
    assign hit_dir  = (paddr == port_cfg_pkg::ADDR_PORT_ZERO_DIRECTION);
    assign hit_cfg  = (paddr == port_cfg_pkg::ADDR_PORT_OUTPUT_CONFIG);
    assign hit_p3   = (paddr == port_cfg_pkg::ADDR_FOURTH_PORT_INPUT);
    assign hit_sts  = (paddr == port_cfg_pkg::ADDR_IRQ_STATUS);
    assign hit_msk  = (paddr == port_cfg_pkg::ADDR_IRQ_MASK);
    assign hit_any  = hit_data | hit_dir | hit_cfg | hit_p3 | hit_sts | hit_msk;

    // Per-register write strobes, one for each register that holds state.
    logic wr_cfg;
    logic wr_dir;
    logic wr_data;
    logic wr_sts;
    logic wr_msk;
    assign wr_cfg  = wr_en && hit_cfg;
    assign wr_dir  = wr_en && hit_dir;
    assign wr_data = wr_en && hit_data;
    assign wr_sts  = wr_en && hit_sts;
    assign wr_msk  = wr_en && hit_msk;

    // Zero wait states keep software polling simple; unmapped addresses raise pslverr.
    // An unmapped write changes nothing and an unmapped read returns zero, so a
    // stray access is reported without side effects.
    assign pready  = 1'b1;
    assign pslverr = access && !hit_any;

    // Configuration bits; no stop-mode recovery input exists so only presetn clears them.
    // Reserved bits have no flops, which is why their writes vanish and their
    // reads come from a constant.
    logic push_pull_q;
    logic comp_out_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            push_pull_q <= 1'b1;
            comp_out_q  <= 1'b0;
        end
        else if (wr_cfg)
        begin
            push_pull_q <= pwdata[port_cfg_pkg::CFG_PUSH_PULL_BIT];
            comp_out_q  <= pwdata[port_cfg_pkg::CFG_COMP_OUT_BIT];
        end
    end

    // Nibble direction bits, one means input.
    // Both reset to input so nothing is driven before software sets the pins up;
    // a nibble turned to output drives whatever the latch already holds.
    logic dir_high_q;
    logic dir_low_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_high_q <= 1'b1;
            dir_low_q  <= 1'b1;
        end
        else if (wr_dir)
        begin
            dir_high_q <= pwdata[port_cfg_pkg::DIR_HIGH_NIBBLE_BIT];
            dir_low_q  <= pwdata[port_cfg_pkg::DIR_LOW_NIBBLE_BIT];
        end
    end

    // Output latch; pin 7 is not written while the transmitter owns it.
    logic [7:0] data_q;
    logic       tx_en;
    logic       pin7_writable;
    assign tx_en         = serial_control[port_cfg_pkg::SERIAL_TX_EN_BIT];
    assign pin7_writable = !tx_en && !dir_high_q;
    // The latch keeps its value through direction changes, so a nibble turned
    // to output shows what was last written rather than a fresh value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data_q <= port_cfg_pkg::DATA_RESET;
        else if (wr_data)
        begin
            for (int b = 0; b < port_cfg_pkg::PORT_WIDTH; b++)
            begin
                if (b != port_cfg_pkg::TX_PIN_BIT)
                    data_q[b] <= pwdata[b];
                else if (pin7_writable)
                    data_q[b] <= pwdata[b];
            end
        end
    end

    // Pin drivers: open-drain releases the pin for a one instead of driving high.
    // The enable follows the level combinationally, which keeps the two in step
    // without an extra cycle of delay.
    // Pin 7 still needs its nibble set to output before transmit data reaches it.
    logic [7:0] level;
    genvar i;
    generate
        for (i = 0; i < port_cfg_pkg::PORT_WIDTH; i++)
        begin : g_pin
            logic is_out;
            assign is_out = (i >= port_cfg_pkg::NIBBLE_WIDTH) ? !dir_high_q : !dir_low_q;
            if (i == port_cfg_pkg::TX_PIN_BIT)
                assign level[i] = tx_en ? serial_tx_data : data_q[i];
            else
                assign level[i] = data_q[i];
            assign port_zero_out[i] = level[i];
            assign port_zero_oe[i]  = is_out && (push_pull_q || !level[i]);
        end
    endgenerate

    // Analog mode controls the comparators and diverts the fourth input.
    // The comparators lose power in stop mode, so software must leave analog mode
    // before relying on a fourth-port input to wake the device; nothing here enforces it.
    logic analog;
    assign analog            = fourth_port_mode[port_cfg_pkg::MODE_ANALOG_BIT];
    assign comparator_enable = analog;

    // Fourth port input view; inputs one and two show comparator results in analog mode.
    logic [3:0] p3_view;
    always_comb
    begin
        p3_view = fourth_port_in;
        if (analog)
        begin
            // The reference input has no digital reader in analog mode.
            p3_view[port_cfg_pkg::P3_REF_ONE_BIT] = 1'b1;
            p3_view[port_cfg_pkg::P3_CMP_ONE_BIT] = comparator_one_result;
            p3_view[port_cfg_pkg::P3_CMP_TWO_BIT] = comparator_two_result;
            // A zero here means a recovery condition is present.
            p3_view[port_cfg_pkg::P3_IN_BIT3]     = recovery_condition_n;
        end
    end

    // Falling-edge detection on bit 3 source; the source changes with analog mode.
    // The previous value resets high, the pin's idle level, so no false edge follows
    // reset. A mode change can look like an edge when the two sources differ, so
    // software should clear the status bits after switching modes.
    logic bit3_prev_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bit3_prev_q <= 1'b1;
        else
            bit3_prev_q <= p3_view[port_cfg_pkg::P3_IN_BIT3];
    end
    logic fall3;
    assign fall3 = bit3_prev_q && !p3_view[port_cfg_pkg::P3_IN_BIT3];
    assign external_interrupt_b = fall3 && !analog;
    assign recovery_interrupt   = fall3 && analog;

    // Sticky status; a new event wins over a write-one clear in the same cycle.
    // Losing an edge is worse than reporting one twice, so the set has priority.
    logic [port_cfg_pkg::IRQ_WIDTH-1:0] sts_q;
    logic [port_cfg_pkg::IRQ_WIDTH-1:0] msk_q;
    logic [port_cfg_pkg::IRQ_WIDTH-1:0] ev;
    assign ev[port_cfg_pkg::IRQ_EXT_B_BIT]    = external_interrupt_b;
    assign ev[port_cfg_pkg::IRQ_RECOVERY_BIT] = recovery_interrupt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sts_q <= '0;
        else if (wr_sts)
            sts_q <= (sts_q & ~pwdata[port_cfg_pkg::IRQ_WIDTH-1:0]) | ev;
        else
            sts_q <= sts_q | ev;
    end
    // Mask bits let status bits onto the single level interrupt.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            msk_q <= '0;
        else if (wr_msk)
            msk_q <= pwdata[port_cfg_pkg::IRQ_WIDTH-1:0];
    end
    assign irq = |(sts_q & msk_q);

    // Read data mux; reserved and write-only bits of direction and config read as ones; other unused bits read zero.
    // Reads have no side effects, so the mux may follow the address in any phase.
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (hit_data)
            prdata[7:0] = port_zero_in;
        else if (hit_dir)
            prdata[7:0] = port_cfg_pkg::DIR_RESERVED_ONES
                        | {1'b0, dir_high_q, 5'b0_0000, dir_low_q};
        else if (hit_cfg)
            prdata[7:0] = port_cfg_pkg::CFG_READ_VALUE;
        else if (hit_p3)
            prdata[port_cfg_pkg::P3_WIDTH-1:0] = p3_view;
        else if (hit_sts)
            prdata[port_cfg_pkg::IRQ_WIDTH-1:0] = sts_q;
        else if (hit_msk)
            prdata[port_cfg_pkg::IRQ_WIDTH-1:0] = msk_q;
    end

    // Elaboration checks: the pin loop assumes a package width equal to the pins, the transmit
    // pin in the upper nibble, and a status vector that holds both events.
    if (port_cfg_pkg::PORT_WIDTH != $bits(port_zero_out))
    begin : g_chk_width
        $error("port width does not match the pins");
    end
    if (port_cfg_pkg::TX_PIN_BIT < port_cfg_pkg::NIBBLE_WIDTH)
    begin : g_chk_tx
        $error("transmit pin must sit in the upper nibble");
    end
    if (port_cfg_pkg::IRQ_WIDTH <= port_cfg_pkg::IRQ_RECOVERY_BIT)
    begin : g_chk_irq
        $error("status too narrow for its events");
    end

    // Timer controls are picked out by name so the routing sees single selects.
    // Keeping the positions in the package lets the routing follow a register move.
    logic tmr_one_sel_hi;
    logic tmr_one_sel_lo;
    logic tmr_zero_sel;
    logic tmr_two_sel;
    logic ir_amp_sel;
    assign tmr_one_sel_hi = timer_control_one[port_cfg_pkg::TMR_ONE_SEL_HI_BIT];
    assign tmr_one_sel_lo = timer_control_one[port_cfg_pkg::TMR_ONE_SEL_LO_BIT];
    assign tmr_zero_sel   = timer_control_zero[port_cfg_pkg::TMR_ZERO_SEL_BIT];
    assign tmr_two_sel    = timer_control_two[port_cfg_pkg::TMR_TWO_SEL_BIT];
    assign ir_amp_sel     = fourth_port_mode[port_cfg_pkg::MODE_IR_AMP_BIT];

    // Fourth port output routing.
    // Comparator routing overrides the timers on the first and last output pins.
    p3_output_mux u_mux
    (
        .comp_out_en               (comp_out_q),
        .ir_amp_sel                (ir_amp_sel),
        .timer_one_b5              (tmr_one_sel_hi),
        .timer_one_b4              (tmr_one_sel_lo),
        .timer_zero_b0             (tmr_zero_sel),
        .timer_two_b0              (tmr_two_sel),
        .digital_out               (fourth_port_digital_out),
        .eight_bit_timer_output    (eight_bit_timer_output),
        .sixteen_bit_timer_output  (sixteen_bit_timer_output),
        .combine_logic_out         (combine_logic_out),
        .comparator_one_output     (comparator_one_result),
        .comparator_two_output     (comparator_two_result),
        .infrared_amplifier_output (infrared_amplifier_output),
        .pin_out                   (fourth_port_out)
    );
endmodule // port_config_and_nibble_io

// File: tb/port_cfg_chk_assertions.sv
// Port-level checker of the port configuration block.
`timescale 1ns/1ns
module port_cfg_chk
(
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Pins and controls
    input wire logic [7:0]  port_zero_in,
    input wire logic [7:0]  port_zero_out,
    input wire logic [7:0]  port_zero_oe,
    input wire logic [7:0]  serial_control,
    input wire logic        serial_tx_data,
    input wire logic [7:0]  fourth_port_mode,
    input wire logic [3:0]  fourth_port_in,
    input wire logic        comparator_enable,
    input wire logic        external_interrupt_b,
    input wire logic        recovery_condition_n,
    input wire logic        recovery_interrupt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase of a read; prdata is combinational, so it is judged there.
    wire rd_phase = psel && penable && !pwrite;
    AST_RST_INPUT: assert property ($rose(presetn) |-> port_zero_oe == 8'h00) else $error("oe set after reset");
    // A driven high bit means push/pull, so its whole nibble must drive.
    AST_NIB_HI: assert property ((port_zero_oe[7:4] & port_zero_out[7:4]) != 4'h0
        |-> port_zero_oe[7:4] == 4'hf) else $error("upper nibble split");
    AST_NIB_LO: assert property ((port_zero_oe[3:0] & port_zero_out[3:0]) != 4'h0
        |-> port_zero_oe[3:0] == 4'hf) else $error("lower nibble split");
    AST_TX_PIN: assert property (serial_control[7] |-> port_zero_out[7] == serial_tx_data) else $error("tx pin");
    AST_CMP_EN: assert property (comparator_enable == fourth_port_mode[1]) else $error("comparator enable");
    AST_CFG_RD: assert property (rd_phase && paddr == 12'hf00 |-> prdata[7:0] == 8'hff) else $error("cfg read");
    AST_DIR_RD: assert property (rd_phase && paddr == 12'h0f8 |-> (prdata[7:0] & 8'hbe) == 8'hbe)
        else $error("dir read");
    AST_DAT_RD: assert property (rd_phase && paddr == 12'h000 |-> prdata[7:0] == port_zero_in)
        else $error("data read");
    AST_EXT_B: assert property ($fell(fourth_port_in[3]) && !fourth_port_mode[1]
        |-> ##[0:2] external_interrupt_b) else $error("no interrupt b");
    // In analog mode a falling fourth input must not raise interrupt b.
    AST_NO_EXT_B: assert property (fourth_port_mode[1] && $past(fourth_port_mode[1])
        && $fell(fourth_port_in[3]) |-> !external_interrupt_b) else $error("interrupt b in analog");
    // In analog mode a new recovery condition raises the recovery pulse at once.
    AST_REC: assert property (fourth_port_mode[1] && $past(fourth_port_mode[1])
        && $fell(recovery_condition_n) |-> recovery_interrupt) else $error("no recovery interrupt");
    COV_EXT_B: cover property (external_interrupt_b);
    COV_REC: cover property (recovery_interrupt);
    COV_TX: cover property (serial_control[7] && port_zero_oe[7]);
    COV_CFG: cover property (rd_phase && paddr == 12'hf00);
endmodule // port_cfg_chk

bind port_config_and_nibble_io port_cfg_chk u_port_cfg_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .port_zero_in, .port_zero_out, .port_zero_oe, .serial_control, .serial_tx_data, .fourth_port_mode,
    .fourth_port_in, .comparator_enable, .external_interrupt_b, .recovery_condition_n, .recovery_interrupt);

// File: tb/port_config_and_nibble_io_tb_top.sv
// Self-checking testbench of the port configuration block.
`timescale 1ns/1ns
module port_config_and_nibble_io_tb_top;
    localparam logic [11:0] A_DAT = port_cfg_pkg::ADDR_PORT_ZERO_DATA;
    localparam logic [11:0] A_DIR = port_cfg_pkg::ADDR_PORT_ZERO_DIRECTION;
    localparam logic [11:0] A_CFG = port_cfg_pkg::ADDR_PORT_OUTPUT_CONFIG;
    localparam logic [11:0] A_P3  = port_cfg_pkg::ADDR_FOURTH_PORT_INPUT;
    localparam logic [11:0] A_ST  = port_cfg_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] A_MSK = port_cfg_pkg::ADDR_IRQ_MASK;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, serial_tx_data;
    logic        cmp1, cmp2, ir_out, rec_n, tmr8, tmr16, comb_out, recovery_interrupt;
    logic        comparator_enable, external_interrupt_b, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  port_zero_in, port_zero_out, port_zero_oe, serial_control, fourth_port_mode, tc0, tc1, tc2;
    logic [3:0]  fourth_port_in, dig, fourth_port_out;
    int          n_fail, num_checks;
    // Timer routing table: controls, sources, expected pins 7 to 4.
    logic [10:0] tmr [6] = '{11'b1000_100_0001, 11'b0001_010_0010, 11'b0100_010_0100,
                             11'b0010_100_0100, 11'b0110_001_0100, 11'b0110_110_0000};
    port_config_and_nibble_io u_port_config_and_nibble_io
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .port_zero_in, .port_zero_out, .port_zero_oe, .serial_control, .serial_tx_data,
        .fourth_port_mode, .timer_control_zero(tc0), .timer_control_one(tc1), .timer_control_two(tc2),
        .fourth_port_in, .comparator_one_result(cmp1), .comparator_two_result(cmp2),
        .infrared_amplifier_output(ir_out), .recovery_condition_n(rec_n), .fourth_port_digital_out(dig),
        .eight_bit_timer_output(tmr8), .sixteen_bit_timer_output(tmr16), .combine_logic_out(comb_out),
        .fourth_port_out, .comparator_enable, .external_interrupt_b, .recovery_interrupt, .irq
    );
    // One APB transfer; an idle cycle follows so strobes are never driven twice in a step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Watchdog; the sequence needs well under a thousand cycles.
    initial
    begin
        #50000;
        n_fail++;
        test_done();
    end
    // Main sequence.
    initial
    begin
        {psel, penable, pwrite, serial_tx_data, ir_out, tmr8, tmr16, comb_out, presetn} = '0;
        {paddr, pwdata, serial_control, fourth_port_mode, tc0, tc1, tc2} = '0;
        {cmp1, cmp2, rec_n, port_zero_in, fourth_port_in, dig} = {3'b111, 8'h3c, 4'hf, 4'h6};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("oe_rst", 8'h00, port_zero_oe);
        chk("p3_rst", 8'h06, {4'h0, fourth_port_out});
        apb(1'b0, A_DIR, 8'h00);
        chk("dir_rst", 8'hff, rd[7:0]);
        apb(1'b1, A_DIR, 8'h00);
        apb(1'b0, A_DIR, 8'h00);
        chk("dir_out", 8'hbe, rd[7:0]);
        apb(1'b1, A_DAT, 8'ha5);
        chk("out_pp", 8'ha5, port_zero_out);
        chk("oe_pp", 8'hff, port_zero_oe);
        apb(1'b0, A_DAT, 8'h00);
        chk("data_rd", 8'h3c, rd[7:0]);
        apb(1'b1, A_CFG, 8'h00);
        chk("oe_od", 8'h5a, port_zero_oe);
        apb(1'b0, A_CFG, 8'h00);
        chk("cfg_rd", 8'hff, rd[7:0]);
        apb(1'b1, A_CFG, 8'h04);
        apb(1'b1, A_DIR, 8'h40);
        chk("oe_lo", 8'h0f, port_zero_oe);
        apb(1'b1, A_DAT, 8'h00);
        chk("pin7_in", 8'h80, port_zero_out);
        apb(1'b1, A_DIR, 8'h01);
        chk("oe_hi", 8'hf0, port_zero_oe);
        serial_control <= 8'h80;
        @(posedge pclk);
        chk("tx_pin", 8'h00, port_zero_out);
        apb(1'b1, A_DAT, 8'h7f);
        serial_control <= 8'h00;
        @(posedge pclk);
        chk("pin7_tx", 8'hff, port_zero_out);
        apb(1'b1, A_CFG, 8'h05);
        for (int k = 0; k < 2; k++)
        begin
            fourth_port_mode <= {5'h00, k[0], 2'b00};
            @(posedge pclk);
            chk("p3_cmp", 8'h0f ^ k[7:0], {4'h0, fourth_port_out});
        end
        apb(1'b1, A_CFG, 8'h04);
        dig <= 4'h0;
        foreach (tmr[k])
        begin
            {tc0[0], tc1[5:4], tc2[0], tmr8, tmr16, comb_out} <= tmr[k][10:4];
            @(posedge pclk);
            chk("p3_tmr", {4'h0, tmr[k][3:0]}, {4'h0, fourth_port_out});
        end
        fourth_port_mode <= 8'h00;
        apb(1'b1, A_MSK, 8'h03);
        apb(1'b0, A_P3, 8'h00);
        chk("p3_dig", 8'h0f, rd[7:0]);
        fourth_port_in <= 4'h7;
        repeat (3) @(posedge pclk);
        chk("irq_on", 8'h01, {7'h00, irq});
        apb(1'b1, A_ST, 8'h01);
        apb(1'b0, A_ST, 8'h00);
        chk("st_clr", 8'h00, rd[7:0]);
        chk("irq_off", 8'h00, {7'h00, irq});
        {fourth_port_mode, cmp2, fourth_port_in} <= {8'h02, 1'b0, 4'hf};
        apb(1'b0, A_P3, 8'h00);
        chk("p3_ana", 8'h0b, rd[7:0]);
        chk("cmp_en", 8'h01, {7'h00, comparator_enable});
        {rec_n, fourth_port_in} <= {1'b0, 4'h7};
        repeat (3) @(posedge pclk);
        apb(1'b0, A_ST, 8'h00);
        chk("st_rec", 8'h02, rd[7:0]);
        apb(1'b1, A_MSK, 8'h01);
        chk("irq_msk", 8'h00, {7'h00, irq});
        apb(1'b0, 12'h100, 8'h00);
        chk("unmapped", 8'h01, {7'h00, err});
        chk("unm_rd", 8'h00, rd[7:0]);
        test_done();
    end
endmodule // port_config_and_nibble_io_tb_top
